// [hvr_pkg.sv]
package hvr_pkg;

  localparam int unsigned HOLD_WIDTH = 10;

  localparam logic [7:0] ADDR_HOLD_HIGH     = 8'h16;
  localparam logic [7:0] ADDR_HOLD_LOW      = 8'h17;
  localparam logic [7:0] ADDR_FREERUN_HIGH  = 8'h18;
  localparam logic [7:0] ADDR_FREERUN_LOW   = 8'h19;
  localparam logic [7:0] ADDR_CONV_DISABLE  = 8'h1A;

  localparam logic [1:0] HOLD_HIGH_RESET    = 2'h2;
  localparam logic [1:0] FREERUN_HIGH_RESET = 2'h1;
  localparam logic [7:0] FREERUN_LOW_RESET  = 8'hFF;
  localparam logic       ADC_DISABLE_RESET  = 1'h0;
  localparam logic       DAC_DISABLE_RESET  = 1'h0;

  localparam int unsigned ADC_DISABLE_BIT   = 1;
  localparam int unsigned DAC_DISABLE_BIT   = 0;

  localparam logic [9:0] SETTLED_RESET      = 10'h200;

endpackage : hvr_pkg

// [hvr_if.sv]
`timescale 1ns/1ps
interface hvr_if;
  logic [9:0] sample;
  logic [9:0] settled;
  logic       settle_strobe;

  modport producer
  (
    output sample,
    input  settled,
    input  settle_strobe
  );

  modport settler
  (
    input  sample,
    output settled,
    output settle_strobe
  );
endinterface : hvr_if

// [hvr_settle.sv]
`timescale 1ns/1ps
module hvr_settle
  import hvr_pkg::*;
(
  input  wire logic     ref_clk,
  input  wire logic     rst_b,
  hvr_if.settler        link
);

  logic [9:0] prev_q;
  logic [9:0] prev_d;
  logic [9:0] settled_q;
  logic [9:0] settled_d;
  logic       strobe_q;
  logic       strobe_d;

  // The settled copy only moves when two back-to-back samples agree.
  always_comb
  begin
    prev_d    = link.sample;
    settled_d = settled_q;
    strobe_d  = 1'b0;
    if (link.sample == prev_q) // RL1
    begin
      settled_d = prev_q;
      strobe_d  = (prev_q != settled_q);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_q    <= SETTLED_RESET;
      settled_q <= SETTLED_RESET;
      strobe_q  <= 1'b0;
    end
    else
    begin
      prev_q    <= prev_d;
      settled_q <= settled_d;
      strobe_q  <= strobe_d;
    end
  end

  assign link.settled       = settled_q;
  assign link.settle_strobe = strobe_q;

endmodule : hvr_settle

// [hvr_regs.sv]
`timescale 1ns/1ps
// How it works
// RL1: ADC value is sampled each clock; settled copy updates when two samples agree.
// RL2: High register read returns settled bits 9:8 and latches bits 7:0.
// RL3: Low register read returns byte latched by the previous high read.
// RL4: Holdover high field is bits 1:0, read-only, reset binary 10.
// RL5: Free-run mode drives loop filter voltage from the 10-bit free-run code.
// RL6: Free-run high write updates code bits 9:8; reset binary 01.
// RL7: Free-run low write updates code bits 7:0; reset 0xFF.
// RL8: Control bit 1 drives ADC disable output; reset 0.
// RL9: Control bit 0 drives DAC disable output; reset 0.
// RL10: Reserved bits read zero and ignore writes.
module hvr_regs
  import hvr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [9:0] holdover_adc_value,
  input  wire logic       freerun_mode,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic      [9:0] freerun_voltage_code,
  output logic      [9:0] loop_filter_voltage_pin,
  output logic            adc_disable,
  output logic            dac_disable
);

  hvr_if link ();

  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  logic [9:0] sync3_q;
  logic [9:0] adc_stable_q;
  logic [9:0] adc_stable_d;

  // The converter output arrives unsynchronised; three stages guard it.
  always_comb
  begin
    adc_stable_d = adc_stable_q;
    if (sync2_q == sync3_q)
    begin
      adc_stable_d = sync3_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_q      <= SETTLED_RESET;
      sync2_q      <= SETTLED_RESET;
      sync3_q      <= SETTLED_RESET;
      adc_stable_q <= SETTLED_RESET;
    end
    else
    begin
      sync1_q      <= holdover_adc_value;
      sync2_q      <= sync1_q;
      sync3_q      <= sync2_q;
      adc_stable_q <= adc_stable_d;
    end
  end

  assign link.sample = adc_stable_q; // RL1

  hvr_settle u_settle
  (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .link    (link)
  );

  logic [7:0] low_latch_q;
  logic [7:0] low_latch_d;
  logic [1:0] fr_high_q;
  logic [1:0] fr_high_d;
  logic [7:0] fr_low_q;
  logic [7:0] fr_low_d;
  logic       adc_dis_q;
  logic       adc_dis_d;
  logic       dac_dis_q;
  logic       dac_dis_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [9:0] lpf_q;
  logic [9:0] lpf_d;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  always_comb
  begin
    low_latch_d = low_latch_q;
    fr_high_d   = fr_high_q;
    fr_low_d    = fr_low_q;
    adc_dis_d   = adc_dis_q;
    dac_dis_d   = dac_dis_q;
    rdata_d     = rdata_q;
    lpf_d       = lpf_q;
    if (reg_write)
    begin
      if (hit(reg_addr, ADDR_FREERUN_HIGH))
      begin
        fr_high_d = reg_wdata[1:0]; // RL6 RL10
      end
      if (hit(reg_addr, ADDR_FREERUN_LOW))
      begin
        fr_low_d = reg_wdata; // RL7
      end
      if (hit(reg_addr, ADDR_CONV_DISABLE))
      begin
        adc_dis_d = reg_wdata[ADC_DISABLE_BIT]; // RL8
        dac_dis_d = reg_wdata[DAC_DISABLE_BIT]; // RL9
      end
    end
    if (reg_read)
    begin
      case (reg_addr)
        ADDR_HOLD_HIGH:
        begin
          rdata_d     = {6'h00, link.settled[9:8]}; // RL2 RL4
          low_latch_d = link.settled[7:0]; // RL2
        end
        ADDR_HOLD_LOW:     rdata_d = low_latch_q; // RL3
        ADDR_FREERUN_HIGH: rdata_d = {6'h00, fr_high_q}; // RL10
        ADDR_FREERUN_LOW:  rdata_d = fr_low_q;
        ADDR_CONV_DISABLE: rdata_d = {6'h00, adc_dis_q, dac_dis_q}; // RL10
        default:           rdata_d = 8'h00;
      endcase
    end
    lpf_d = freerun_mode ? {fr_high_q, fr_low_q} : link.settled; // RL5
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_latch_q <= 8'h00;
      fr_high_q   <= FREERUN_HIGH_RESET;
      fr_low_q    <= FREERUN_LOW_RESET;
      adc_dis_q   <= ADC_DISABLE_RESET;
      dac_dis_q   <= DAC_DISABLE_RESET;
      rdata_q     <= 8'h00;
      lpf_q       <= SETTLED_RESET;
    end
    else
    begin
      low_latch_q <= low_latch_d;
      fr_high_q   <= fr_high_d;
      fr_low_q    <= fr_low_d;
      adc_dis_q   <= adc_dis_d;
      dac_dis_q   <= dac_dis_d;
      rdata_q     <= rdata_d;
      lpf_q       <= lpf_d;
    end
  end

  assign reg_rdata               = rdata_q;
  assign freerun_voltage_code    = {fr_high_q, fr_low_q};
  assign loop_filter_voltage_pin = lpf_q;
  assign adc_disable             = adc_dis_q;
  assign dac_disable             = dac_dis_q;

endmodule : hvr_regs

// [hvr_regs_sva.sv]
`timescale 1ns/1ps
module hvr_regs_sva
(
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic       freerun_mode,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [9:0] freerun_voltage_code,
  input wire logic [9:0] loop_filter_voltage_pin,
  input wire logic       adc_disable,
  input wire logic       dac_disable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_adc_follow: assert property
    (reg_write && reg_addr == 8'h1A |=> adc_disable == $past(reg_wdata[1])) else $error("adc");
  a_dac_follow: assert property
    (reg_write && reg_addr == 8'h1A |=> dac_disable == $past(reg_wdata[0])) else $error("dac");
  a_low_write: assert property
    (reg_write && reg_addr == 8'h19 |=> freerun_voltage_code[7:0] == $past(reg_wdata))
    else $error("low");
  a_high_write: assert property
    (reg_write && reg_addr == 8'h18 |=> freerun_voltage_code[9:8] == $past(reg_wdata[1:0]))
    else $error("high");
  a_free_drive: assert property
    ($past(freerun_mode) && $past(rst_b) && $stable(freerun_voltage_code)
     |-> loop_filter_voltage_pin == freerun_voltage_code) else $error("lpf");
  a_unmapped_zero: assert property
    (reg_read && reg_addr > 8'h1A |=> reg_rdata == 8'h00) else $error("unmapped");
  a_high_rsvd: assert property
    (reg_read && reg_addr == 8'h16 |=> reg_rdata[7:2] == 6'h00) else $error("rsvd");
  a_rdata_hold: assert property
    (!reg_read |=> $stable(reg_rdata)) else $error("hold");
  c_read: cover property (reg_read && reg_addr == 8'h17);
  c_write: cover property (reg_write && reg_addr == 8'h18);
  c_free: cover property (freerun_mode);
endmodule : hvr_regs_sva
bind hvr_regs hvr_regs_sva i_hvr_regs_sva (.*);

// [hvr_adc_model.sv]
`timescale 1ns/1ps
module hvr_adc_model
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       adc_disable,
  input  wire logic [9:0] level,
  output logic      [9:0] adc_out
);
  // A disabled converter gives no stable code, so the output toggles every cycle.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      adc_out <= 10'h200;
    end
    else
    begin
      adc_out <= adc_disable ? ~adc_out : level;
    end
  end
endmodule : hvr_adc_model

// [holdover_voltage_regs_bench.sv]
`timescale 1ns/1ps
module holdover_voltage_regs_bench;
  logic       ref_clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       mode = 1'b0;
  logic       we = 1'b0;
  logic       re = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [9:0] level = 10'h200;
  logic [9:0] adc;
  logic [7:0] rd;
  logic [9:0] code;
  logic [9:0] lpf;
  logic       adc_dis;
  logic       dac_dis;
  int         num_errors = 0;
  int         num_checks = 0;
  int         cyc = 0;
  hvr_adc_model i_hvr_adc_model (.ref_clk(ref_clk), .rst_b(rst_b), .adc_disable(adc_dis),
    .level(level), .adc_out(adc));
  hvr_regs i_hvr_regs (.ref_clk(ref_clk), .rst_b(rst_b), .holdover_adc_value(adc),
    .freerun_mode(mode), .reg_write(we), .reg_read(re), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rd), .freerun_voltage_code(code), .loop_filter_voltage_pin(lpf),
    .adc_disable(adc_dis), .dac_disable(dac_dis));
  initial forever #5 ref_clk = ~ref_clk;
  task complete_run;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      complete_run();
    end
  end
  task chk(input logic [9:0] g, input logic [9:0] e);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    we = 1'b1;
    addr = a;
    wd = d;
    @(negedge ref_clk);
    we = 1'b0;
  endtask : wr
  task rdc(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    re = 1'b1;
    addr = a;
    @(negedge ref_clk);
    re = 1'b0;
    chk({2'h0, rd}, {2'h0, e});
  endtask : rdc
  task t_reset;
    rdc(8'h16, 8'h02);
    rdc(8'h17, 8'h00);
    rdc(8'h18, 8'h01);
    rdc(8'h19, 8'hFF);
    rdc(8'h1A, 8'h00);
    chk(code, 10'h1FF);
    $display("reset test done");
  endtask : t_reset
  task t_hold;
    level = 10'h2A5;
    repeat (10) @(negedge ref_clk);
    rdc(8'h16, 8'h02);
    level = 10'h15A;
    repeat (10) @(negedge ref_clk);
    rdc(8'h17, 8'hA5);
    rdc(8'h16, 8'h01);
    rdc(8'h17, 8'h5A);
    $display("holdover test done");
  endtask : t_hold
  task t_free;
    wr(8'h18, 8'hFF);
    wr(8'h19, 8'h3C);
    rdc(8'h18, 8'h03);
    rdc(8'h19, 8'h3C);
    mode = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(lpf, 10'h33C);
    mode = 1'b0;
    wr(8'h16, 8'hFF);
    chk(lpf, 10'h15A);
    rdc(8'h16, 8'h01);
    rdc(8'h20, 8'h00);
    $display("free-run test done");
  endtask : t_free
  task t_conv;
    wr(8'h1A, 8'hFE);
    chk({8'h00, adc_dis, dac_dis}, 10'h002);
    rdc(8'h1A, 8'h02);
    repeat (10) @(negedge ref_clk);
    rdc(8'h16, 8'h01);
    rdc(8'h17, 8'h5A);
    wr(8'h1A, 8'h01);
    chk({8'h00, adc_dis, dac_dis}, 10'h001);
    $display("converter test done");
  endtask : t_conv
  initial
  begin
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    t_reset();
    t_hold();
    t_free();
    t_conv();
    complete_run();
  end
endmodule : holdover_voltage_regs_bench
